// *** verilog/fault_supervisor.sv ***
// Converter fault supervisor: lockout, strap decode, OV/OC/OT shutdown, prebias start.
// Assumes measurement words and comparator flags arrive asynchronously from the analog side.
`timescale 1ns/10ps
module fault_supervisor
  import fault_sup_pkg::*;
(
  input  wire logic                 aclk,                 // 200 MHz clock
  input  wire logic                 aresetn,              // Sync reset, active low
  input  wire logic [fault_sup_pkg::AW-1:0] s_axi_awaddr, // Write address
  input  wire logic                 s_axi_awvalid,        // Write address valid
  output logic                      s_axi_awready,        // Write address ready
  input  wire logic [31:0]          s_axi_wdata,          // Write data
  input  wire logic [3:0]           s_axi_wstrb,          // Write strobes
  input  wire logic                 s_axi_wvalid,         // Write data valid
  output logic                      s_axi_wready,         // Write data ready
  output logic [1:0]                s_axi_bresp,          // Write response
  output logic                      s_axi_bvalid,         // Write response valid
  input  wire logic                 s_axi_bready,         // Write response ready
  input  wire logic [fault_sup_pkg::AW-1:0] s_axi_araddr, // Read address
  input  wire logic                 s_axi_arvalid,        // Read address valid
  output logic                      s_axi_arready,        // Read address ready
  output logic [31:0]               s_axi_rdata,          // Read data
  output logic [1:0]                s_axi_rresp,          // Read response
  output logic                      s_axi_rvalid,         // Read data valid
  input  wire logic                 s_axi_rready,         // Read data ready
  input  wire logic [4:0]           address_strap_pin,    // Decoded address strap code
  input  wire logic [4:0]           input_undervoltage_lockout_strap_code,      // Decoded lockout resistor code
  input  wire logic [15:0]          vin_mv,               // Input voltage, mV
  input  wire logic [15:0]          sense_positive_input, // Output voltage, mV
  input  wire logic [15:0]          iout_avg,             // Average output current
  input  wire logic                 peak_over,            // Peak current above peak limit
  input  wire logic                 cycle_tick,           // One per switching cycle
  input  wire logic [15:0]          temp_c,               // Internal temperature, C
  input  wire logic [15:0]          fsw_khz,              // Switching frequency, kHz
  input  wire logic                 coord_bus_in,         // Coordination line level
  output logic                      module_coordination_bus_oe, // Pull line low
  output logic                      module_coordination_bus_o,  // Always low when driven
  output logic                      power_good_output,    // Power good
  output logic                      high_drv_en,          // High-side driver enable
  output logic                      low_drv_en,           // Low-side driver enable
  output logic [15:0]               ref_mv,               // Loop reference, mV
  output logic [15:0]               peak_limit,           // Computed peak current limit
  output logic [6:0]                bus_address           // Serial bus address
);
  import fault_sup_pkg::*;

  // Two-flop synchronisers for every analog-side input
  logic [92:0] s1_r, s2_r;
  always_ff @(posedge aclk)
  begin
    s1_r <= {vin_mv, sense_positive_input, iout_avg, temp_c, fsw_khz, peak_over,
             cycle_tick, coord_bus_in, input_undervoltage_lockout_strap_code, address_strap_pin};
    s2_r <= s1_r;
  end
  logic [15:0] vin, vout, iavg, tmp, fsw;
  logic        pk, ctk, cbus, ctk_d_r;
  logic [4:0]  uv_code, sa_code;
  assign {vin, vout, iavg, tmp, fsw, pk, ctk, cbus, uv_code, sa_code} = s2_r;
  always_ff @(posedge aclk) ctk_d_r <= ctk;
  wire cyc = ctk & ~ctk_d_r;

  // Lockout table for resistor codes 0..14 (26.1k..100k)
  function automatic logic [15:0] uv_lookup(input logic [4:0] c);
    logic [15:0] t [0:14];
    t = '{16'h1054, 16'h11EE, 16'h13C4, 16'h15C2, 16'h17F2, 16'h1A5E, 16'h1CFC,
          16'h1FF4, 16'h231E, 16'h26AC, 16'h2A94, 16'h2EE0, 16'h3390, 16'h38CC, 16'h3E80};
    if (c == STRAP_OPEN) return INPUT_UNDERVOLTAGE_LOCKOUT_OPEN_MV;
    if (c == STRAP_RAIL) return INPUT_UNDERVOLTAGE_LOCKOUT_RAIL_MV;
    return (c <= 5'h0E) ? t[c[3:0]] : INPUT_UNDERVOLTAGE_LOCKOUT_OPEN_MV;
  endfunction : uv_lookup

  // Registers
  logic        en_r, en_nxt, init_r, init_nxt, ovr_r, ovr_nxt;
  logic [3:0]  rsp_r, rsp_nxt, st_r, st_nxt;
  logic [15:0] uvl_r, uvl_nxt, ocl_r, ocl_nxt, otl_r, otl_nxt, tgt_r, tgt_nxt;
  logic [15:0] ramp_r, ramp_nxt;
  logic [7:0]  ovp_r, ovp_nxt, pgp_r, pgp_nxt;
  logic [6:0]  addr_r, addr_nxt;
  logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
  logic [AW-1:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic [3:0]  ev;

  wire [15:0] ov_lim = 16'(({16'd0, tgt_r} * (32'd100 + 32'(ovp_r))) / 32'd100);
  wire [15:0] pg_tol = 16'(({16'd0, tgt_r} * 32'(pgp_r)) / 32'd100);

  always_comb
  begin
    en_nxt = en_r; rsp_nxt = rsp_r; uvl_nxt = uvl_r; ocl_nxt = ocl_r;
    otl_nxt = otl_r; tgt_nxt = tgt_r; ovp_nxt = ovp_r; pgp_nxt = pgp_r;
    ramp_nxt = ramp_r; ovr_nxt = ovr_r; addr_nxt = addr_r; init_nxt = 1'b1;
    aw_nxt = aw_r; w_nxt = w_r; b_nxt = b_r; r_nxt = r_r; awa_nxt = awa_r;
    wd_nxt = wd_r; rd_nxt = rd_r; br_nxt = br_r; rr_nxt = rr_r;
    st_nxt = st_r | ev;
    if (!init_r)
    begin
      addr_nxt = (sa_code == STRAP_OPEN) ? ADDR_OPEN : (sa_code == STRAP_GND) ? ADDR_GND :
                 (sa_code < ADDR_CODES) ? ADDR_BASE + 7'(sa_code) : ADDR_OPEN;
      uvl_nxt = uv_lookup(uv_code);
    end
    if (s_axi_awvalid && !aw_r && !b_r) begin aw_nxt = 1'b1; awa_nxt = s_axi_awaddr; end
    if (s_axi_wvalid && !w_r && !b_r) begin w_nxt = 1'b1; wd_nxt = s_axi_wdata; end
    if (aw_r && w_r)
    begin
      aw_nxt = 1'b0; w_nxt = 1'b0; b_nxt = 1'b1; br_nxt = 2'b00;
      unique case (awa_r)
        OFF_CTRL:     en_nxt = wd_r[CTRL_EN_BIT];
        OFF_STATUS:   st_nxt = (st_r & ~wd_r[3:0]) | ev; // set wins
        OFF_UV_LIMIT: begin uvl_nxt = wd_r[15:0]; ovr_nxt = 1'b1; end
        OFF_OV_LIMIT: ovp_nxt = wd_r[7:0];
        OFF_OC_LIMIT: ocl_nxt = wd_r[15:0];
        OFF_OT_LIMIT: otl_nxt = wd_r[15:0];
        OFF_RESPONSE: rsp_nxt = wd_r[3:0];
        OFF_TARGET:   tgt_nxt = wd_r[15:0];
        OFF_RAMP:     ramp_nxt = wd_r[15:0];
        OFF_PG_TOL:   pgp_nxt = wd_r[7:0];
        default:      br_nxt = 2'b10;
      endcase
    end
    if (b_r && s_axi_bready) b_nxt = 1'b0;
    if (s_axi_arvalid && !r_r)
    begin
      r_nxt = 1'b1; rr_nxt = 2'b00; rd_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFF_CTRL:     rd_nxt[0] = en_r;
        OFF_STATUS:   rd_nxt[3:0] = st_r;
        OFF_UV_LIMIT: rd_nxt[15:0] = uvl_r;
        OFF_OV_LIMIT: rd_nxt[7:0] = ovp_r;
        OFF_OC_LIMIT: rd_nxt[15:0] = ocl_r;
        OFF_OT_LIMIT: rd_nxt[15:0] = otl_r;
        OFF_RESPONSE: rd_nxt[3:0] = rsp_r;
        OFF_TARGET:   rd_nxt[15:0] = tgt_r;
        OFF_RAMP:     rd_nxt[15:0] = ramp_r;
        OFF_PG_TOL:   rd_nxt[7:0] = pgp_r;
        OFF_STRAPS:   rd_nxt[23:0] = {ovr_r, addr_r, peak_limit};
        default:      rr_nxt = 2'b10;
      endcase
    end
    else if (r_r && s_axi_rready) r_nxt = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      en_r <= 1'b0; rsp_r <= 4'h0; st_r <= 4'h0; uvl_r <= INPUT_UNDERVOLTAGE_LOCKOUT_OPEN_MV; ocl_r <= OC_RST;
      otl_r <= OT_RST_C; tgt_r <= TARGET_RST_MV; ovp_r <= OV_PCT_RST; pgp_r <= PG_PCT_RST;
      ramp_r <= RAMP_RST_US; ovr_r <= 1'b0; addr_r <= ADDR_OPEN; init_r <= 1'b0;
      aw_r <= 1'b0; w_r <= 1'b0; b_r <= 1'b0; r_r <= 1'b0; awa_r <= '0;
      wd_r <= 32'h0000_0000; rd_r <= 32'h0000_0000; br_r <= 2'b00; rr_r <= 2'b00;
    end
    else
    begin
      en_r <= en_nxt; rsp_r <= rsp_nxt; st_r <= st_nxt; uvl_r <= uvl_nxt; ocl_r <= ocl_nxt;
      otl_r <= otl_nxt; tgt_r <= tgt_nxt; ovp_r <= ovp_nxt; pgp_r <= pgp_nxt;
      ramp_r <= ramp_nxt; ovr_r <= ovr_nxt; addr_r <= addr_nxt; init_r <= init_nxt;
      aw_r <= aw_nxt; w_r <= w_nxt; b_r <= b_nxt; r_r <= r_nxt; awa_r <= awa_nxt;
      wd_r <= wd_nxt; rd_r <= rd_nxt; br_r <= br_nxt; rr_r <= rr_nxt;
    end
  end

  // Power stage sequencer
  state_t      fsm_r, fsm_nxt;
  logic [2:0]  hit_r, hit_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [15:0] us_r, us_nxt, ref_r, ref_nxt, pb_r, pb_nxt, pkl_r, pkl_nxt;
  logic        pg_r, pg_nxt, hi_r, hi_nxt, lo_r, lo_nxt, cb_r, cb_nxt, dn_r, dn_nxt;
  logic [3:0]  ev_r, ev_nxt;
  assign ev = ev_r;
  wire uv = vin < uvl_r;
  wire ov = vout > ov_lim;
  wire ot = tmp > otl_r;
  wire oc = (iavg > ocl_r) || (cyc && pk && hit_r == PEAK_HITS - 3'h1);
  wire any_f = uv | ov | ot | oc;
  // Peak trips are one-cycle pulses, so the latched cause also counts
  wire retry = (uv & rsp_r[RSP_UV_BIT]) | (ov & rsp_r[RSP_OV_BIT]) |
               ((oc | ev_r[ST_OC_BIT]) & rsp_r[RSP_OC_BIT]) | (ot & rsp_r[RSP_OT_BIT]);
  // Signed so that a prebias above target ramps down
  wire signed [33:0] ramp_step = (($signed({1'b0, tgt_r}) - $signed({1'b0, pb_r})) *
                                  $signed({1'b0, us_r})) / $signed({1'b0, ramp_r});

  always_comb
  begin
    fsm_nxt = fsm_r; cnt_nxt = cnt_r; us_nxt = us_r; ref_nxt = ref_r; pb_nxt = pb_r;
    pg_nxt = 1'b0; hi_nxt = 1'b0; lo_nxt = 1'b0; cb_nxt = 1'b0; dn_nxt = dn_r;
    ev_nxt = 4'h0; hit_nxt = hit_r;
    // Ripple term grows with (vin - tgt_r) / fsw
    pkl_nxt = ocl_r + 16'(({16'd0, vin - tgt_r} * 32'd8) / {16'd0, fsw | 16'h0001});
    if (cyc) hit_nxt = pk ? ((hit_r == PEAK_HITS) ? hit_r : hit_r + 3'h1) : 3'h0;
    unique case (fsm_r)
      ST_OFF:
        if (en_r && !uv && cbus) fsm_nxt = ST_SAMPLE;
      ST_SAMPLE:
      begin
        pb_nxt = vout;
        if (vout > ov_lim)
        begin
          ev_nxt[ST_OV_BIT] = 1'b1; fsm_nxt = ST_FAULT;
        end
        else
        begin
          ref_nxt = vout; dn_nxt = vout > tgt_r; cnt_nxt = 32'd0; us_nxt = 16'd0;
          fsm_nxt = ST_RAMP;
        end
      end
      ST_RAMP:
      begin
        hi_nxt = 1'b1; lo_nxt = !dn_r && ref_r >= pb_r;
        cnt_nxt = (cnt_r == RAMP_TICK_CYC - 1) ? 32'd0 : cnt_r + 32'd1;
        if (cnt_r == RAMP_TICK_CYC - 1) us_nxt = us_r + 16'd1;
        // Linear interpolation: lands on target exactly at the ramp time
        ref_nxt = (us_r >= ramp_r) ? tgt_r : 16'($signed({18'd0, pb_r}) + ramp_step);
        if (any_f)
        begin
          ev_nxt = {ot, oc, ov, uv}; fsm_nxt = ST_FAULT;
        end
        else if (us_r >= ramp_r) fsm_nxt = ST_RUN;
        pg_nxt = dn_r && us_r >= ramp_r;
      end
      ST_RUN:
      begin
        hi_nxt = 1'b1; lo_nxt = 1'b1; ref_nxt = tgt_r;
        pg_nxt = !any_f && st_r == 4'h0 && vout + pg_tol >= tgt_r &&
                 vout <= tgt_r + pg_tol;
        if (!en_r) fsm_nxt = ST_OFF;
        else if (any_f)
        begin
          ev_nxt = {ot, oc, ov, uv}; fsm_nxt = ST_FAULT;
        end
      end
      ST_FAULT:
      begin
        ev_nxt = {ot, oc, ov, uv}; cb_nxt = 1'b1; cnt_nxt = 32'd0; ref_nxt = 16'd0;
        fsm_nxt = retry ? ST_WAIT : (uv && !rsp_r[RSP_UV_BIT] ? ST_OFF : ST_FAULT);
        if (!en_r) fsm_nxt = ST_OFF;
      end
      ST_WAIT:
      begin
        cnt_nxt = cnt_r + 32'd1;
        if (cnt_r >= RETRY_CYCLES - 1)
        begin
          cnt_nxt = 32'd0;
          if (!uv && !ov && tmp + OT_HYST_C < otl_r) fsm_nxt = ST_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fsm_r <= ST_OFF; cnt_r <= 32'd0; us_r <= 16'd0; ref_r <= 16'd0; pb_r <= 16'd0;
      pg_r <= 1'b0; hi_r <= 1'b0; lo_r <= 1'b0; cb_r <= 1'b0; dn_r <= 1'b0;
      ev_r <= 4'h0; hit_r <= 3'h0; pkl_r <= 16'd0;
    end
    else
    begin
      fsm_r <= fsm_nxt; cnt_r <= cnt_nxt; us_r <= us_nxt; ref_r <= ref_nxt; pb_r <= pb_nxt;
      pg_r <= pg_nxt; hi_r <= hi_nxt; lo_r <= lo_nxt; cb_r <= cb_nxt; dn_r <= dn_nxt;
      ev_r <= ev_nxt; hit_r <= hit_nxt; pkl_r <= pkl_nxt;
    end
  end

  assign s_axi_awready = aw_r;
  assign s_axi_wready  = w_r;
  assign s_axi_bvalid  = b_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = r_r;
  assign s_axi_rvalid  = r_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;
  assign power_good_output = pg_r;
  assign high_drv_en = hi_r;
  assign low_drv_en = lo_r;
  assign ref_mv = ref_r;
  assign peak_limit = pkl_r;
  assign bus_address = addr_r;
  assign module_coordination_bus_oe = cb_r;
  assign module_coordination_bus_o = 1'b0;

  AST_UV_BLOCKS: assert property (@(posedge aclk) disable iff (!aresetn)
    fsm_r == ST_OFF && uv |=> fsm_r != ST_SAMPLE) else $error("Started under lockout");
  AST_OV_SHUT: assert property (@(posedge aclk) disable iff (!aresetn)
    fsm_r == ST_RUN && ov |=> fsm_r == ST_FAULT ##1 !hi_r) else $error("No OV shutdown");
  AST_PEAK_FIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    oc && iavg <= ocl_r |-> hit_r == 3'h4) else $error("Peak trip count wrong");
  AST_PB_OV: assert property (@(posedge aclk) disable iff (!aresetn)
    fsm_r == ST_SAMPLE && ov |=> fsm_r == ST_FAULT) else $error("Prebias OV missed");
  AST_PG_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    fsm_r == ST_FAULT |=> !power_good_output) else $error("PG during fault");
  AST_NO_RETRY: assert property (@(posedge aclk) disable iff (!aresetn)
    fsm_r == ST_FAULT && ot && rsp_r == 4'h0 && en_r |=> fsm_r == ST_FAULT)
    else $error("Retried without setting");
  AST_OD_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    module_coordination_bus_oe |-> !module_coordination_bus_o) else $error("Line driven high");
  AST_FAULT_SPREAD: assert property (@(posedge aclk) disable iff (!aresetn)
    fsm_r == ST_FAULT |=> module_coordination_bus_oe) else $error("Fault not spread");
  AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_r[ST_OT_BIT] |=> st_r[ST_OT_BIT]) else $error("Fault not latched");
  COV_RUN: cover property (@(posedge aclk) fsm_r == ST_RAMP ##1 fsm_r == ST_RUN);
  COV_RETRY: cover property (@(posedge aclk) fsm_r == ST_WAIT ##1 fsm_r == ST_OFF);
  COV_DOWN: cover property (@(posedge aclk) fsm_r == ST_RAMP && dn_r && pg_r);
endmodule : fault_supervisor

// *** verilog/fault_sup_pkg.sv ***
// Constants for the converter fault supervisor: register map, strap codes, timing.
// Assumes a 200 MHz aclk and digital measurement words from the analog front end.
package fault_sup_pkg;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned AW               = 8;
  // Register byte offsets
  localparam logic [AW-1:0] OFF_CTRL       = 8'h00;
  localparam logic [AW-1:0] OFF_STATUS     = 8'h04;
  localparam logic [AW-1:0] OFF_UV_LIMIT   = 8'h08;
  localparam logic [AW-1:0] OFF_OV_LIMIT   = 8'h0C;
  localparam logic [AW-1:0] OFF_OC_LIMIT   = 8'h10;
  localparam logic [AW-1:0] OFF_OT_LIMIT   = 8'h14;
  localparam logic [AW-1:0] OFF_RESPONSE   = 8'h18;
  localparam logic [AW-1:0] OFF_TARGET     = 8'h1C;
  localparam logic [AW-1:0] OFF_RAMP       = 8'h20;
  localparam logic [AW-1:0] OFF_PG_TOL     = 8'h24;
  localparam logic [AW-1:0] OFF_STRAPS     = 8'h28;
  // Fields: ctrl bit 0 = enable; response bits 0 uv,1 ov,2 oc,3 ot retry enables
  localparam int unsigned   CTRL_EN_BIT    = 0;
  localparam int unsigned   RSP_UV_BIT     = 0;
  localparam int unsigned   RSP_OV_BIT     = 1;
  localparam int unsigned   RSP_OC_BIT     = 2;
  localparam int unsigned   RSP_OT_BIT     = 3;
  // Status bits (sticky, write one to clear)
  localparam int unsigned   ST_UV_BIT      = 0;
  localparam int unsigned   ST_OV_BIT      = 1;
  localparam int unsigned   ST_OC_BIT      = 2;
  localparam int unsigned   ST_OT_BIT      = 3;
  // Voltages in millivolts, temperature in degrees C, 16-bit words
  localparam logic [15:0] INPUT_UNDERVOLTAGE_LOCKOUT_OPEN_MV     = 16'h1194; // 4500
  localparam logic [15:0] INPUT_UNDERVOLTAGE_LOCKOUT_RAIL_MV     = 16'h2A30; // 10800
  localparam logic [4:0]  STRAP_OPEN       = 5'h1F;
  localparam logic [4:0]  STRAP_RAIL       = 5'h1E;
  localparam logic [4:0]  STRAP_GND        = 5'h1D;
  localparam logic [6:0]  ADDR_BASE        = 7'h19;
  localparam logic [6:0]  ADDR_OPEN        = 7'h28;
  localparam logic [6:0]  ADDR_GND         = 7'h26;
  localparam logic [4:0]  ADDR_CODES       = 5'h19; // 25 codes, 19h..31h
  localparam logic [15:0] TARGET_RST_MV    = 16'h04B0; // 1200
  localparam logic [7:0]  OV_PCT_RST       = 8'h0F;    // 15 percent
  localparam logic [7:0]  PG_PCT_RST       = 8'h0A;    // 10 percent
  localparam logic [15:0] OT_RST_C         = 16'h007D; // 125
  localparam logic [15:0] OT_HYST_C        = 16'h000F; // 15
  localparam logic [15:0] OC_RST           = 16'h0021;
  localparam logic [2:0]  PEAK_HITS        = 3'h5;
  // Retry delay and ramp units
  localparam int unsigned RETRY_DELAY_US   = 10;
  localparam int unsigned RETRY_CYCLES     = RETRY_DELAY_US * CLK_MHZ;
  localparam int unsigned RAMP_TICK_US     = 1;
  localparam int unsigned RAMP_TICK_CYC    = RAMP_TICK_US * CLK_MHZ;
  localparam logic [15:0] RAMP_RST_US      = 16'h01F4; // 500
  typedef enum logic [2:0] {ST_OFF, ST_SAMPLE, ST_RAMP, ST_RUN, ST_FAULT, ST_WAIT}
    state_t;
endpackage : fault_sup_pkg

// *** dv/coord_peer.sv ***
// Far side of the coordination line: one pull-up and one peer that may pull low.
// Assumes the supervisor's enable means it pulls the line low.
`timescale 1ns/10ps
module coord_peer (
  input  wire logic dut_oe,    // Supervisor drives the line
  input  wire logic dut_o,     // Supervisor drive level
  input  wire logic peer_pull, // Peer holds the line low
  output logic      line       // Resolved line level
);
  // Open drain: any party pulling low wins, else the pull-up holds it high
  assign line = ((dut_oe && !dut_o) || peer_pull) ? 1'b0 : 1'b1;
endmodule : coord_peer

// *** dv/converter_fault_supervisor_tb.sv ***
// Testbench for the fault supervisor: AXI4-Lite tasks and fault scenarios.
// Assumes the package constants and the coordination line model.
`timescale 1ns/10ps
module converter_fault_supervisor_tb;
  import fault_sup_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, pk = 0, tick = 0, peer_pull = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [1:0] rs;
  logic [4:0] sa = 5'h1F, us = 5'h1F;
  logic [15:0] vin = 16'h2EE0, vs = 0, iavg = 0, temp = 16'h0019, fsw = 16'h0215;
  wire awready, wready, bvalid, arready, rvalid, line, oe, o, pg, hd, ld;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] ref_mv, plim;
  wire [6:0] addr;
  int err_count = 0;
  int compares = 0;
  logic [4:0] tsa [4] = '{5'h00, 5'h18, 5'h1D, 5'h1F};
  logic [6:0] tad [4] = '{7'h19, 7'h31, 7'h26, 7'h28};
  logic [4:0] tus [4] = '{5'h1E, 5'h00, 5'h0E, 5'h1F};
  logic [15:0] tuv [4] = '{16'h2A30, 16'h1054, 16'h3E80, 16'h1194};

  fault_supervisor fault_supervisor_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .address_strap_pin(sa), .input_undervoltage_lockout_strap_code(us), .vin_mv(vin),
    .sense_positive_input(vs), .iout_avg(iavg), .peak_over(pk), .cycle_tick(tick),
    .temp_c(temp), .fsw_khz(fsw), .coord_bus_in(line), .module_coordination_bus_oe(oe),
    .module_coordination_bus_o(o), .power_good_output(pg), .high_drv_en(hd),
    .low_drv_en(ld), .ref_mv(ref_mv), .peak_limit(plim), .bus_address(addr));

  coord_peer coord_peer_i (.dut_oe(oe), .dut_o(o), .peer_pull(peer_pull), .line(line));

  initial
  begin
    forever #2.5 aclk = ~aclk;
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axw

  task axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    arvalid <= 1'b0;
    rready <= 1'b0;
  endtask : axr

  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(n, rd, e);
  endtask : rchk

  task boot();
    aresetn <= 1'b0;
    cyc(12);
    aresetn <= 1'b1;
    cyc(2);
    axw(OFF_RAMP, 32'h0000_0004);
  endtask : boot

  task wait_drv(input logic e, input int n);
    int i;
    i = 0;
    while (hd !== e && i < n)
    begin
      @(posedge aclk);
      i++;
    end
    chk("high_drv_en", hd, e);
  endtask : wait_drv

  task stay_off(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge aclk);
      seen = seen | hd | ld | pg;
    end
    chk("stay_off", seen, 0);
  endtask : stay_off

  task ticks(input int n, input logic p);
    repeat (n)
    begin
      pk <= p;
      tick <= 1'b1;
      cyc(3);
      tick <= 1'b0;
      cyc(3);
    end
  endtask : ticks

  // Boot with a prebias, enable, check the reference starts at the prebias
  task start(input logic [15:0] pb);
    vs <= pb;
    boot();
    axw(OFF_CTRL, 32'h0000_0001);
    wait_drv(1'b1, 2000);
    chk("ref_start", ref_mv, pb);
    cyc(4 * RAMP_TICK_CYC + 20);
  endtask : start

  task give_verdict();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  initial
  begin
    cyc(60000);
    err_count++;
    give_verdict();
  end

  initial
  begin
    for (int k = 0; k < 4; k++)
    begin
      sa <= tsa[k];
      us <= tus[k];
      boot();
      chk("bus_address", addr, tad[k]);
      rchk("uv_limit", OFF_UV_LIMIT, tuv[k]);
      sa <= 5'h05;
      cyc(4);
      chk("addr_held", addr, tad[k]);
    end
    rchk("ov_pct", OFF_OV_LIMIT, 32'h0000_000F);
    rchk("ot_lim", OFF_OT_LIMIT, 32'h0000_007D);
    rchk("pg_tol", OFF_PG_TOL, 32'h0000_000A);
    rchk("oc_lim", OFF_OC_LIMIT, 32'h0000_0021);
    rchk("response", OFF_RESPONSE, 32'h0000_0000);
    axr(8'h30);
    chk("unmapped", {rs, rd[29:0]}, 32'h8000_0000);
    vin <= 16'h0FA0;
    axw(OFF_CTRL, 32'h0000_0001);
    stay_off(600);
    vin <= 16'h2EE0;
    peer_pull <= 1'b1;
    stay_off(100);
    peer_pull <= 1'b0;
    start(16'h0258);
    chk("ref_final", ref_mv, TARGET_RST_MV);
    chk("low_drv", ld, 1'b1);
    vs <= TARGET_RST_MV;
    cyc(20);
    chk("pg_on", pg, 1'b1);
    chk("peak_limit", plim, 16'h00C3);
    ticks(4, 1'b1);
    ticks(1, 1'b0);
    ticks(4, 1'b1);
    chk("oc_early", hd, 1'b1);
    ticks(1, 1'b1);
    wait_drv(1'b0, 50);
    chk("pg_oc", pg, 1'b0);
    rchk("st_oc", OFF_STATUS, 32'h0000_0004);
    pk <= 1'b0;
    start(16'h0514);
    chk("pg_high_pb", pg, 1'b1);
    temp <= 16'h0082;
    wait_drv(1'b0, 50);
    rchk("st_ot", OFF_STATUS, 32'h0000_0008);
    temp <= 16'h0019;
    start(16'h0258);
    vs <= 16'h0578;
    wait_drv(1'b0, 50);
    rchk("st_ov", OFF_STATUS, 32'h0000_0002);
    stay_off(2500);
    vs <= 16'h05DC;
    boot();
    axw(OFF_CTRL, 32'h0000_0001);
    stay_off(1500);
    chk("coord_pull", {oe, o}, 2'b10);
    rchk("st_pb_ov", OFF_STATUS, 32'h0000_0002);
    start(16'h0000);
    axw(OFF_RESPONSE, 32'h0000_0008);
    temp <= 16'h0082;
    wait_drv(1'b0, 50);
    temp <= 16'h0073;
    stay_off(RETRY_CYCLES + 500);
    temp <= 16'h0064;
    wait_drv(1'b1, 3 * RETRY_CYCLES);
    vin <= 16'h0FA0;
    wait_drv(1'b0, 50);
    rchk("st_uv", OFF_STATUS, 32'h0000_0009);
    give_verdict();
  end
endmodule : converter_fault_supervisor_tb
